// *** rtl/dio_direct_io.sv ***
`timescale 1ns/10ps
`default_nettype none
module dio_direct_io import dio_pkg::*; (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   // Processor access
   input wire logic [ADDR_W-1:0] PROC_ADDR,
   input wire logic [DATA_W-1:0] PROC_DATA,
   input wire logic PROC_WR,
   input wire logic PROC_RD,
   input wire logic MANUAL_MODE,
   // Operator entry
   input wire logic OP_CHAN_LOAD,
   input wire logic OP_SUB_LOAD,
   input wire logic OP_ARM_WRITE,
   input wire logic OP_ARM_READ,
   input wire logic OP_ENTER,
   input wire logic OP_STEP,
   input wire logic [DATA_W-1:0] OP_VALUE,
   // Input devices
   input wire logic [DATA_W-1:0] IN_REG_PINS,
   input wire logic [DATA_W-1:0] REMOTE_IN,
   // Strobes and bus
   output logic [NUM_STB-1:0] STROBE,
   output logic [DATA_W-1:0] DATA_BUS,
   // Output devices
   output logic [DATA_W-1:0] HOLD_OUT,
   output logic [DAC_W-1:0] DAC_CODE,
   output logic [DEC_W-1:0] DEC_LINES,
   output logic FLAG_OUT,
   // Display and self-test
   output logic [DATA_W-1:0] ENTRY_DISPLAY,
   output logic [1:0] SELF_TEST_FAULT_INDICATORS
);
   // Input pin synchroniser
   logic [DATA_W-1:0] in_meta_q, in_sync_q;
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         in_meta_q <= RST_WORD;
         in_sync_q <= RST_WORD;
      end else begin
         in_meta_q <= IN_REG_PINS;
         in_sync_q <= in_meta_q;
      end
   end

   // Self-test state
   dio_st_t st_q, st_d;
   logic [ADDR_W-1:0] st_cnt_q, st_cnt_d;
   logic [DATA_W-1:0] scratch_q, scratch_d;
   logic flt_addr_q, flt_addr_d, flt_data_q, flt_data_d;
   logic [NUM_STB-1:0] st_dec;
   logic st_pass;

   always_comb begin
      st_d = st_q;
      st_cnt_d = st_cnt_q;
      scratch_d = scratch_q;
      flt_addr_d = flt_addr_q;
      flt_data_d = flt_data_q;
      st_dec = NUM_STB'(1) << st_cnt_q;
      unique case (st_q)
         ST_ADDR: begin
            if (!st_dec[st_cnt_q] || !$onehot(st_dec)) flt_addr_d = 1'b1;
            st_cnt_d = st_cnt_q + 6'h01;
            if (st_cnt_q == 6'h3f) st_d = ST_DATA;
         end
         ST_DATA: begin
            scratch_d = st_cnt_q[0] ? PAT_B : PAT_A;
            st_d = ST_CHECK;
         end
         ST_CHECK: begin
            if (scratch_q != (st_cnt_q[0] ? PAT_B : PAT_A)) flt_data_d = 1'b1;
            st_cnt_d = st_cnt_q + 6'h01;
            st_d = st_cnt_q[0] ? ST_DONE : ST_DATA;
         end
         ST_DONE: begin
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_q <= ST_ADDR;
         st_cnt_q <= 6'h00;
         scratch_q <= RST_WORD;
         flt_addr_q <= 1'b0;
         flt_data_q <= 1'b0;
      end else begin
         st_q <= st_d;
         st_cnt_q <= st_cnt_d;
         scratch_q <= scratch_d;
         flt_addr_q <= flt_addr_d;
         flt_data_q <= flt_data_d;
      end
   end

   assign st_pass = (st_q == ST_DONE) && !flt_addr_q && !flt_data_q;
   // Lamps lit until self-test has passed
   assign SELF_TEST_FAULT_INDICATORS = {~st_pass, ~st_pass};

   // Operator entry state
   logic [CHAN_W-1:0] chan_q, chan_d;
   logic [SUB_W-1:0] sub_q, sub_d;
   dio_arm_t arm_q, arm_d;
   logic [DATA_W-1:0] last_q, last_d;
   logic op_go;

   always_comb begin
      chan_d = chan_q;
      sub_d = sub_q;
      arm_d = arm_q;
      last_d = last_q;
      if (OP_CHAN_LOAD) begin
         chan_d = OP_VALUE[CHAN_W-1:0];
         arm_d = ARM_NONE;
      end
      if (OP_SUB_LOAD) begin
         sub_d = OP_VALUE[SUB_W-1:0];
         arm_d = ARM_NONE;
      end
      if (OP_ARM_WRITE) arm_d = ARM_WRITE;
      if (OP_ARM_READ) arm_d = ARM_READ;
      if (OP_ENTER) last_d = OP_VALUE;
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         chan_q <= '0;
         sub_q <= '0;
         arm_q <= ARM_NONE;
         last_q <= RST_WORD;
      end else begin
         chan_q <= chan_d;
         sub_q <= sub_d;
         arm_q <= arm_d;
         last_q <= last_d;
      end
   end

   // Access request: operator first, then processor
   assign op_go = st_pass && (arm_q != ARM_NONE) && (OP_ENTER || OP_STEP);

   logic req_wr, req_rd;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_data;
   always_comb begin
      req_wr = 1'b0;
      req_rd = 1'b0;
      req_addr = PROC_ADDR;
      req_data = PROC_DATA;
      if (op_go) begin
         req_addr = {chan_q, sub_q};
         req_data = OP_ENTER ? OP_VALUE : last_q;
         req_wr = (arm_q == ARM_WRITE);
         req_rd = (arm_q == ARM_READ);
      end else begin
         req_wr = PROC_WR && !MANUAL_MODE;
         req_rd = PROC_RD;
      end
   end

   // Strobe stage
   logic [NUM_STB-1:0] stb_q, stb_d;
   logic [DATA_W-1:0] bus_q, bus_d;
   logic stb_wr_q, stb_rd_q;
   logic [ADDR_W-1:0] stb_addr_q;
   always_comb begin
      stb_d = '0;
      if (req_wr || req_rd) stb_d = NUM_STB'(1) << req_addr;
      bus_d = req_wr ? req_data : bus_q;
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stb_q <= '0;
         bus_q <= RST_WORD;
         stb_wr_q <= 1'b0;
         stb_rd_q <= 1'b0;
         stb_addr_q <= '0;
      end else begin
         stb_q <= stb_d;
         bus_q <= bus_d;
         stb_wr_q <= req_wr;
         stb_rd_q <= req_rd;
         stb_addr_q <= req_addr;
      end
   end

   // Input devices onto the bus during read strobe
   logic [DATA_W-1:0] rd_bus;
   logic rd_hit;
   always_comb begin
      rd_bus = RST_WORD;
      rd_hit = 1'b0;
      if (stb_rd_q && stb_q[STB_IN_REG]) begin
         rd_bus = in_sync_q;
         rd_hit = 1'b1;
      end else if (stb_rd_q && stb_q[STB_REMOTE]) begin
         rd_bus = REMOTE_IN;
         rd_hit = 1'b1;
      end
   end

   // Output devices and display
   logic [DATA_W-1:0] hold_q, hold_d, disp_q, disp_d;
   logic [DAC_W-1:0] dac_q, dac_d;
   logic [DEC_W-1:0] dec_q, dec_d;
   logic flag_q, flag_d;
   always_comb begin
      hold_d = hold_q;
      dac_d = dac_q;
      dec_d = dec_q;
      flag_d = flag_q;
      disp_d = disp_q;
      if (stb_wr_q && stb_q[STB_HOLD]) hold_d = bus_q;
      if (stb_wr_q && stb_q[STB_DAC]) dac_d = bus_q ^ DAC_SIGN_FLIP;
      if (stb_wr_q && stb_q[STB_DEC]) dec_d = DEC_W'(1) << bus_q[DEC_SEL_W-1:0];
      if (stb_wr_q && stb_q[STB_FLAG]) flag_d = bus_q[0];
      if (rd_hit) disp_d = rd_bus;
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         hold_q <= RST_WORD;
         dac_q <= RST_DAC;
         dec_q <= RST_DEC;
         flag_q <= 1'b0;
         disp_q <= RST_WORD;
      end else begin
         hold_q <= hold_d;
         dac_q <= dac_d;
         dec_q <= dec_d;
         flag_q <= flag_d;
         disp_q <= disp_d;
      end
   end

   assign STROBE = stb_q;
   assign DATA_BUS = stb_rd_q ? rd_bus : bus_q;
   assign HOLD_OUT = hold_q;
   assign DAC_CODE = dac_q;
   assign DEC_LINES = dec_q;
   assign FLAG_OUT = flag_q;
   assign ENTRY_DISPLAY = disp_q;

   // Checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_hold_wr;
      stb_wr_q && stb_q[STB_HOLD];
   endsequence
   sequence s_in_rd;
      stb_rd_q && stb_q[STB_IN_REG];
   endsequence

   a_strobe_one_hot: assert property ((req_wr || req_rd) |=> $onehot(STROBE) && STROBE[$past(req_addr)])
      else $error("strobe not one-hot at requested address");
   a_input_bus_drive: assert property (s_in_rd |-> DATA_BUS == in_sync_q)
      else $error("input register not on data bus");
   a_read_display_show: assert property (s_in_rd ##1 1'b1 |-> ENTRY_DISPLAY == $past(in_sync_q))
      else $error("entry display missed read word");
   a_dac_code_conv: assert property (stb_wr_q && stb_q[STB_DAC] |=> DAC_CODE == ($past(bus_q) ^ DAC_SIGN_FLIP))
      else $error("DAC code not converted");
   a_decoder_line_set: assert property (stb_wr_q && stb_q[STB_DEC] |=> $onehot(DEC_LINES)
      && DEC_LINES[$past(bus_q[DEC_SEL_W-1:0])])
      else $error("decoder line wrong");
   a_hold_latch_word: assert property (PROC_WR && !MANUAL_MODE && !op_go && PROC_ADDR == STB_HOLD ##1 s_hold_wr
      |=> HOLD_OUT == $past(PROC_DATA, 2))
      else $error("holding register lost word");
   a_manual_no_write: assert property (MANUAL_MODE && !op_go |=> !stb_wr_q)
      else $error("processor write in manual mode");
   a_op_gate_pass: assert property (!st_pass && !(PROC_WR || PROC_RD) |=> STROBE == '0)
      else $error("operator strobe before self-test pass");
   a_op_step_pulse: assert property (op_go && OP_STEP && !OP_ENTER && arm_q == ARM_WRITE
      |=> stb_wr_q && STROBE[{$past(chan_q), $past(sub_q)}] ##1 (!$past(stb_q[STB_HOLD]) || HOLD_OUT == $past(last_q, 2)))
      else $error("knob step did not pulse strobe");
   a_unassigned_none: assert property (stb_wr_q && stb_addr_q > STB_FLAG |=> $stable(HOLD_OUT) && $stable(DAC_CODE)
      && $stable(DEC_LINES) && $stable(FLAG_OUT))
      else $error("unassigned strobe changed a device");
   a_self_test_time: assert property ($rose(ARST_N) |-> ##[60:80] (st_q == ST_DONE))
      else $error("self-test did not finish");
endmodule : dio_direct_io
`default_nettype wire

// *** rtl/dio_pkg.sv ***
package dio_pkg;
   // Bus, strobe address and output device widths
   localparam int DATA_W = 16;
   localparam int CHAN_W = 4;
   localparam int SUB_W = 2;
   localparam int ADDR_W = CHAN_W + SUB_W;
   localparam int NUM_STB = 64;
   localparam int DAC_W = 16;
   localparam int DEC_W = 8;
   localparam int DEC_SEL_W = 3;

   // Strobe addresses {channel, subchannel} of the devices built here
   localparam logic [ADDR_W-1:0] STB_HOLD = 6'h00;
   localparam logic [ADDR_W-1:0] STB_DAC = 6'h01;
   localparam logic [ADDR_W-1:0] STB_DEC = 6'h02;
   localparam logic [ADDR_W-1:0] STB_FLAG = 6'h03;
   localparam logic [ADDR_W-1:0] STB_IN_REG = 6'h04;
   localparam logic [ADDR_W-1:0] STB_REMOTE = 6'h05;

   // Two's complement to offset binary for the DAC
   localparam logic [DATA_W-1:0] DAC_SIGN_FLIP = 16'h8000;

   // Self-test data patterns
   localparam logic [DATA_W-1:0] PAT_A = 16'h5555;
   localparam logic [DATA_W-1:0] PAT_B = 16'haaaa;

   // Reset values
   localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
   localparam logic [DAC_W-1:0] RST_DAC = 16'h8000;
   localparam logic [DEC_W-1:0] RST_DEC = 8'h00;

   typedef enum logic [1:0] {ARM_NONE, ARM_WRITE, ARM_READ} dio_arm_t;
   typedef enum logic [1:0] {ST_ADDR, ST_DATA, ST_CHECK, ST_DONE} dio_st_t;
endpackage : dio_pkg

// *** testbench/dio_direct_io_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, s); end end
module dio_direct_io_tb_top import dio_pkg::*; ();
   logic SYS_CLK = 1'b0;
   logic ARST_N = 1'b0;
   logic MANUAL_MODE = 1'b0;
   // Operator pulses: chan, sub, arm write, arm read, enter, step
   logic [5:0] ops = 6'h00;
   logic [DATA_W-1:0] OP_VALUE = 16'h0000;
   logic [DATA_W-1:0] IN_REG_PINS = 16'h0000;
   logic [DATA_W-1:0] REMOTE_IN = 16'h0000;
   logic [ADDR_W-1:0] PROC_ADDR;
   logic [DATA_W-1:0] PROC_DATA, DATA_BUS, HOLD_OUT, DAC_CODE, ENTRY_DISPLAY;
   logic PROC_WR, PROC_RD, FLAG_OUT;
   logic [NUM_STB-1:0] STROBE;
   logic [DEC_W-1:0] DEC_LINES;
   logic [1:0] SELF_TEST_FAULT_INDICATORS;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   dio_proc_model pm_u (.clk(SYS_CLK), .addr(PROC_ADDR), .data(PROC_DATA), .wr(PROC_WR), .rd(PROC_RD));
   dio_direct_io dut_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PROC_ADDR(PROC_ADDR), .PROC_DATA(PROC_DATA),
      .PROC_WR(PROC_WR), .PROC_RD(PROC_RD), .MANUAL_MODE(MANUAL_MODE), .OP_CHAN_LOAD(ops[5]),
      .OP_SUB_LOAD(ops[4]), .OP_ARM_WRITE(ops[3]), .OP_ARM_READ(ops[2]), .OP_ENTER(ops[1]),
      .OP_STEP(ops[0]), .OP_VALUE(OP_VALUE), .IN_REG_PINS(IN_REG_PINS), .REMOTE_IN(REMOTE_IN),
      .STROBE(STROBE), .DATA_BUS(DATA_BUS), .HOLD_OUT(HOLD_OUT), .DAC_CODE(DAC_CODE),
      .DEC_LINES(DEC_LINES), .FLAG_OUT(FLAG_OUT), .ENTRY_DISPLAY(ENTRY_DISPLAY),
      .SELF_TEST_FAULT_INDICATORS(SELF_TEST_FAULT_INDICATORS));
   initial begin
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   task automatic stop_test();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         stop_test();
      end
   end
   // Processor access, strobe and bus checked, device settled on return
   task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, e);
      pm_u.acc(w, a, d);
      #1;
      `CHK("stb", 64'h1 << a, STROBE)
      `CHK("bus", e, DATA_BUS)
      @(posedge SYS_CLK);
      #1;
   endtask : acc
   task automatic op(input logic [5:0] p, input logic [DATA_W-1:0] v);
      @(posedge SYS_CLK);
      ops <= p;
      OP_VALUE <= v;
      @(posedge SYS_CLK);
      ops <= 6'h00;
      #1;
   endtask : op
   task automatic t_reset();
      @(posedge SYS_CLK);
      #1;
      `CHK("dac", RST_DAC, DAC_CODE)
      `CHK("lamp", 2'h3, SELF_TEST_FAULT_INDICATORS)
      `CHK("stb", 64'h0, STROBE)
      `CHK("bus", RST_WORD, DATA_BUS)
      repeat (4) @(posedge SYS_CLK);
      ARST_N <= 1'b1;
      op(6'h08, 16'h0000);
      op(6'h02, 16'h1234);
      `CHK("stb", 64'h0, STROBE)
      `CHK("lamp", 2'h3, SELF_TEST_FAULT_INDICATORS)
      for (int i = 0; i < 200 && SELF_TEST_FAULT_INDICATORS !== 2'h0; i++) @(posedge SYS_CLK);
      #1;
      `CHK("lamp", 2'h0, SELF_TEST_FAULT_INDICATORS)
      `CHK("hold", RST_WORD, HOLD_OUT)
   endtask : t_reset
   task automatic t_write();
      logic [DATA_W-1:0] w;
      acc(1'b1, STB_HOLD, 16'h5555, 16'h5555);
      `CHK("hold", 16'h5555, HOLD_OUT)
      acc(1'b1, STB_HOLD, 16'haaaa, 16'haaaa);
      `CHK("hold", 16'haaaa, HOLD_OUT)
      for (int i = 0; i < 3; i++) begin
         w = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'hffff;
         acc(1'b1, STB_DAC, w, w);
         `CHK("dac", w ^ DAC_SIGN_FLIP, DAC_CODE)
      end
      for (int i = 0; i < 8; i++) begin
         w = 16'hfff8 | 16'(i);
         acc(1'b1, STB_DEC, w, w);
         `CHK("dec", 8'h1 << i, DEC_LINES)
      end
      acc(1'b1, STB_FLAG, 16'h0001, 16'h0001);
      `CHK("flag", 1'b1, FLAG_OUT)
      acc(1'b1, STB_FLAG, 16'hfffe, 16'hfffe);
      `CHK("flag", 1'b0, FLAG_OUT)
      `CHK("hold", 16'haaaa, HOLD_OUT)
   endtask : t_write
   task automatic t_read();
      @(posedge SYS_CLK);
      IN_REG_PINS <= 16'h1357;
      REMOTE_IN <= 16'hc246;
      repeat (3) @(posedge SYS_CLK);
      acc(1'b0, STB_IN_REG, 16'h0000, 16'h1357);
      `CHK("disp", 16'h1357, ENTRY_DISPLAY)
      acc(1'b0, STB_REMOTE, 16'h0000, 16'hc246);
      `CHK("disp", 16'hc246, ENTRY_DISPLAY)
   endtask : t_read
   task automatic t_unassigned();
      acc(1'b1, 6'h3f, 16'h0f0f, 16'h0f0f);
      `CHK("hold", 16'haaaa, HOLD_OUT)
      `CHK("dac", 16'h7fff, DAC_CODE)
      `CHK("dec", 8'h80, DEC_LINES)
      `CHK("flag", 1'b0, FLAG_OUT)
      acc(1'b0, STB_HOLD, 16'h0000, 16'h0000);
      `CHK("disp", 16'hc246, ENTRY_DISPLAY)
   endtask : t_unassigned
   task automatic t_manual();
      @(posedge SYS_CLK);
      MANUAL_MODE <= 1'b1;
      pm_u.acc(1'b1, STB_HOLD, 16'h1234);
      repeat (2) @(posedge SYS_CLK);
      #1;
      `CHK("hold", 16'haaaa, HOLD_OUT)
      op(6'h20, 16'h0000);
      op(6'h10, 16'h0000);
      op(6'h08, 16'h0000);
      op(6'h02, 16'h00ff);
      `CHK("stb", 64'h1, STROBE)
      @(posedge SYS_CLK);
      #1;
      `CHK("hold", 16'h00ff, HOLD_OUT)
      op(6'h01, 16'h1111);
      `CHK("stb", 64'h1, STROBE)
      @(posedge SYS_CLK);
      IN_REG_PINS <= 16'h2468;
      op(6'h20, 16'h0001);
      op(6'h01, 16'h0000);
      `CHK("stb", 64'h0, STROBE)
      op(6'h10, 16'h0000);
      op(6'h04, 16'h0000);
      op(6'h02, 16'h0000);
      `CHK("stb", 64'h10, STROBE)
      @(posedge SYS_CLK);
      #1;
      `CHK("disp", 16'h2468, ENTRY_DISPLAY)
      `CHK("hold", 16'h00ff, HOLD_OUT)
   endtask : t_manual
   initial begin
      t_reset();
      t_write();
      t_read();
      t_unassigned();
      t_manual();
      stop_test();
   end
endmodule : dio_direct_io_tb_top
`default_nettype wire

// *** testbench/dio_proc_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dio_proc_model import dio_pkg::*; (
   // Clock
   input wire logic clk,
   // Processor bus
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] data,
   output logic wr,
   output logic rd
);
   initial begin
      addr = '0;
      data = '0;
      wr = 1'b0;
      rd = 1'b0;
   end
   // One-cycle request, then bus scrambled
   task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      data <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      addr <= ~a;
      data <= ~d;
   endtask : acc
endmodule : dio_proc_model
`default_nettype wire
